// File: hdl/ssb_consts.svh
// ssb_consts.svh: offsets, phase points and timing counts of the bus link
// assumes the including file uses the ssb_ package types alongside
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH

// local clock and bus clock periods, in nanoseconds
`define SSB_CLK_PERIOD_NS   50
`define SSB_BUS_PERIOD_NS   400
// local clocks in one bus clock period
`define SSB_PHASES          (`SSB_BUS_PERIOD_NS / `SSB_CLK_PERIOD_NS)
// phase counts just before each registered change
`define SSB_PH_START        3'h7
`define SSB_PH_QUARTER      3'h1
`define SSB_PH_HALF         3'h3
`define SSB_PH_3QUARTER     3'h5
// bus clock is high for the first half of the period
`define SSB_HALF_PHASE      3'h4
// bus clocks of settling after a shared signal deasserts
`define SSB_SETTLE_CLKS     2'h2
// receiver asks the sender to hold off at this fifo level
`define SSB_BLOCK_LEVEL     8
// strobe idle levels: positive high, negative low
`define SSB_STB_POS_IDLE    1'h1
`define SSB_STB_NEG_IDLE    1'h0

`endif

// File: hdl/ssb_pkg.sv
// ssb_pkg: types used by the sender end of the bus link
// assumes constants come from ssb_consts.svh
package ssb_pkg;

    typedef enum logic [1:0] {
        SND_IDLE = 2'b00,
        SND_PRE  = 2'b01,
        SND_DATA = 2'b10
    } ssb_snd_state_e;

    typedef logic [2:0] ssb_phase_t;

endpackage : ssb_pkg

// File: hdl/ssb_link_if.sv
// ssb_link_if: the bus wires between the data sender and the receiver
// assumes each end drives out/oe pairs; wires resolve here
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

interface ssb_link_if #(
    parameter int W = 32
);
    // sender drives
    logic         busClk;
    logic [W-1:0] dataOut;
    logic         dataOe;
    logic         dataStrobePosOut;
    logic         dataStrobeNegOut;
    logic         dataStrobeOe;
    logic         busDataValid;
    // receiver drives (shared open-drain style signal)
    logic         blockNextOut;
    logic         blockNextOe;
    // resolved wire levels
    logic [W-1:0] dataBus;
    logic         dataStrobePos;
    logic         dataStrobeNeg;
    logic         blockNextRequest;

    // undriven bus floats to idle levels through termination
    assign dataBus          = dataOe ? dataOut : '0;
    assign dataStrobePos    = dataStrobeOe ? dataStrobePosOut
                                           : `SSB_STB_POS_IDLE;
    assign dataStrobeNeg    = dataStrobeOe ? dataStrobeNegOut
                                           : `SSB_STB_NEG_IDLE;
    assign blockNextRequest = blockNextOe & blockNextOut;

    modport sender (
        output busClk, dataOut, dataOe, dataStrobePosOut,
               dataStrobeNegOut, dataStrobeOe, busDataValid,
        input  blockNextRequest
    );
    modport receiver (
        input  busClk, dataBus, dataStrobePos, dataStrobeNeg, busDataValid,
        output blockNextOut, blockNextOe
    );
endinterface : ssb_link_if

`default_nettype wire

// File: hdl/ssb_fifo.sv
// ssb_fifo: synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap by themselves
`timescale 1ns/1ps
`default_nettype none

module ssb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData,
    // fill level
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign inReady  = cnt_r != (AW+1)'(DEPTH);
    assign outValid = cnt_r != '0;
    assign outData  = mem[rdPtr_r];
    assign level    = cnt_r;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r   <= '0;
        end else if (ce) begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : ssb_fifo

`default_nettype wire

// File: hdl/ssb_sender.sv
// ssb_sender: data-driving agent end of the bus link; makes the bus clock
// assumes the receiver end keeps the same bus clock period and protocol
// How it works
// - drive and sample only on bus clock rising
// - sampled input affects outputs next edge earliest
// - reply driven two clocks after the cause
// - shared signals settle two clocks after deassert
// - two data transfers per bus clock period
// - only data bus and strobes run source synchronous
// - new data at period start and midpoint
// - strobe edges at quarter and three quarters
// - pre-drive positive strobe before any data
// - both strobes rise and fall each transfer
// - strobes released after the last data
// - receiver captures on strobe difference only
// - data-valid qualifier marks sent data
// - pins registered directly, no extra logic
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

module ssb_sender #(
    parameter int W = 32
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // user words to send
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // bus side
    ssb_link_if.sender        link
);
    ssb_pkg::ssb_snd_state_e state_r;
    ssb_pkg::ssb_phase_t     phase_r;
    ssb_pkg::ssb_phase_t     phaseNxt;

    logic         busClk_r;
    logic [W-1:0] dataOut_r;
    logic         dataOe_r;
    logic         stbPos_r;
    logic         stbNeg_r;
    logic         stbOe_r;
    logic         valid_r;
    logic         inReady_r;

    logic [W-1:0] pairLo_r;
    logic [W-1:0] pairHi_r;
    logic [W-1:0] sendHi_r;
    logic [1:0]   pairCnt_r;
    logic [1:0]   pairCntNxt;
    logic         takeIn;
    logic         atEdge;
    logic         consume;

    // block-next-request arrives from the other domain's logic
    logic         blkS1_r;
    logic         blkS2_r;
    logic         blkS3_r;
    logic         blkLvl_r;
    logic         blocked_r;
    logic [1:0]   settle_r;

    // outputs come straight from flops, no logic before the pins
    assign link.busClk           = busClk_r;
    assign link.dataOut          = dataOut_r;
    assign link.dataOe           = dataOe_r;
    assign link.dataStrobePosOut = stbPos_r;
    assign link.dataStrobeNegOut = stbNeg_r;
    assign link.dataStrobeOe     = stbOe_r;
    assign link.busDataValid     = valid_r;
    assign inReady               = inReady_r;

    // last local clock before a bus clock rising edge
    assign atEdge   = phase_r == `SSB_PH_START;
    assign phaseNxt = phase_r + 3'h1;
    assign takeIn   = inValid && inReady_r;
    // a committed transfer always sends its pair; later pairs obey blocking
    assign consume  = atEdge && ((state_r == ssb_pkg::SND_PRE) ||
                      (state_r == ssb_pkg::SND_DATA && pairCnt_r == 2'h2
                       && !blocked_r));

    always_comb begin
        pairCntNxt = pairCnt_r;
        if (consume) begin
            pairCntNxt = 2'h0;
        end else if (takeIn) begin
            pairCntNxt = pairCnt_r + 2'h1;
        end
    end

    // bus clock divider: period of SSB_PHASES local clocks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r  <= 3'h0;
            busClk_r <= 1'h1;
        end else if (ce) begin
            phase_r  <= phaseNxt;
            busClk_r <= phaseNxt < `SSB_HALF_PHASE;
        end
    end

    // user word pairing: low word first, high word second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pairCnt_r <= 2'h0;
            inReady_r <= 1'h0;
            pairLo_r  <= '0;
            pairHi_r  <= '0;
        end else if (ce) begin
            pairCnt_r <= pairCntNxt;
            inReady_r <= pairCntNxt != 2'h2;
            if (takeIn && pairCnt_r == 2'h0) begin
                pairLo_r <= inData;
            end
            if (takeIn && pairCnt_r == 2'h1) begin
                pairHi_r <= inData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blkS1_r  <= 1'h0;
            blkS2_r  <= 1'h0;
            blkS3_r  <= 1'h0;
            blkLvl_r <= 1'h0;
        end else if (ce) begin
            blkS1_r <= link.blockNextRequest;
            blkS2_r <= blkS1_r;
            blkS3_r <= blkS2_r;
            if (blkS2_r == blkS3_r) begin
                blkLvl_r <= blkS3_r;
            end
        end
    end

    // blocking is sampled at bus clock edges; a release only counts after
    // two deasserted clocks, riding out the wired-OR glitch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blocked_r <= 1'h0;
            settle_r  <= 2'h0;
        end else if (ce && atEdge) begin
            if (blkLvl_r) begin
                blocked_r <= 1'h1;
                settle_r  <= 2'h0;
            end else if (blocked_r) begin
                if (settle_r + 2'h1 >= `SSB_SETTLE_CLKS) begin
                    blocked_r <= 1'h0;
                    settle_r  <= 2'h0;
                end else begin
                    settle_r <= settle_r + 2'h1;
                end
            end
        end
    end

    // transfer sequencing; decisions made in the last phase take effect
    // at the bus clock rising edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ssb_pkg::SND_IDLE;
        end else if (ce && atEdge) begin
            case (state_r)
                ssb_pkg::SND_IDLE: begin
                    if (pairCnt_r == 2'h2 && !blocked_r) begin
                        state_r <= ssb_pkg::SND_PRE;
                    end
                end
                ssb_pkg::SND_PRE: begin
                    state_r <= ssb_pkg::SND_DATA;
                end
                ssb_pkg::SND_DATA: begin
                    if (!consume) begin
                        state_r <= ssb_pkg::SND_IDLE;
                    end
                end
                default: begin
                    state_r <= ssb_pkg::SND_IDLE;
                end
            endcase
        end
    end

    // data bus: two words per bus clock period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataOut_r <= '0;
            dataOe_r  <= 1'h0;
            sendHi_r  <= '0;
        end else if (ce) begin
            if (consume) begin
                dataOut_r <= pairLo_r;
                sendHi_r  <= pairHi_r;
                dataOe_r  <= 1'h1;
            end else if (atEdge) begin
                dataOe_r <= 1'h0;
            end else if (state_r == ssb_pkg::SND_DATA
                         && phase_r == `SSB_PH_HALF) begin
                dataOut_r <= sendHi_r;
            end
        end
    end

    // differential strobes, centred in each data window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stbPos_r <= `SSB_STB_POS_IDLE;
            stbNeg_r <= `SSB_STB_NEG_IDLE;
            stbOe_r  <= 1'h0;
        end else if (ce) begin
            if (atEdge && state_r == ssb_pkg::SND_IDLE
                && pairCnt_r == 2'h2 && !blocked_r) begin
                stbOe_r  <= 1'h1;
                stbPos_r <= `SSB_STB_POS_IDLE;
                stbNeg_r <= `SSB_STB_NEG_IDLE;
            end else if (atEdge && state_r == ssb_pkg::SND_DATA
                         && !consume) begin
                stbOe_r <= 1'h0;
            end else if (state_r == ssb_pkg::SND_DATA) begin
                if (phase_r == `SSB_PH_QUARTER) begin
                    stbPos_r <= ~`SSB_STB_POS_IDLE;
                    stbNeg_r <= ~`SSB_STB_NEG_IDLE;
                end else if (phase_r == `SSB_PH_3QUARTER) begin
                    stbPos_r <= `SSB_STB_POS_IDLE;
                    stbNeg_r <= `SSB_STB_NEG_IDLE;
                end
            end
        end
    end

    // the qualifier is a common-clock signal: it changes only at edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_r <= 1'h0;
        end else if (ce && atEdge) begin
            valid_r <= consume;
        end
    end
endmodule : ssb_sender

`default_nettype wire

// File: hdl/ssb_receiver.sv
// ssb_receiver: data-receiving agent end of the bus link
// assumes bus clock, strobes, data and qualifier arrive asynchronously
// and are sampled here through three flops each
`timescale 1ns/1ps
`default_nettype none
`include "ssb_consts.svh"

module ssb_receiver #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // received words
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData,
    // bus side
    ssb_link_if.receiver      link
);
    localparam int SW = W + 4;
    localparam int AW = $clog2(DEPTH);

    // sync bit order: {busClk, valid, strobePos, strobeNeg, data}
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic          clkLvl_r;
    logic          validLvl_r;
    logic          diffLvl_r;
    logic          busEdge;
    logic          stbStable;
    logic          newDiff;
    logic          stbEvent;

    logic [W-1:0]  capLo_r;
    logic [W-1:0]  capHi_r;
    logic          capFull_r;
    logic [W-1:0]  moveLo_r;
    logic [W-1:0]  moveHi_r;
    logic [1:0]    moveCnt_r;
    logic          fifoReady;
    logic [AW:0]   fifoLevel;
    logic          blkOe_r;

    assign link.blockNextOut = 1'h1;
    assign link.blockNextOe  = blkOe_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (ce) begin
            s1_r <= {link.busClk, link.busDataValid, link.dataStrobePos,
                     link.dataStrobeNeg, link.dataBus};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign busEdge   = s2_r[W+3] && s3_r[W+3] && !clkLvl_r;
    assign stbStable = (s2_r[W+1] == s3_r[W+1]) && (s2_r[W] == s3_r[W])
                       && (s3_r[W+1] != s3_r[W]);
    assign newDiff   = s3_r[W+1] & ~s3_r[W];
    assign stbEvent  = stbStable && (newDiff != diffLvl_r);

    // levels change once stages two and three agree; the qualifier read
    // at a bus edge is therefore the value from the period just ended
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkLvl_r   <= 1'h0;
            validLvl_r <= 1'h0;
            diffLvl_r  <= 1'h1;
        end else if (ce) begin
            if (s2_r[W+3] == s3_r[W+3]) begin
                clkLvl_r <= s3_r[W+3];
            end
            if (s2_r[W+2] == s3_r[W+2]) begin
                validLvl_r <= s3_r[W+2];
            end
            if (stbStable) begin
                diffLvl_r <= newDiff;
            end
        end
    end

    // capture on the strobe difference, with no reference to the bus clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capLo_r   <= '0;
            capHi_r   <= '0;
            capFull_r <= 1'h0;
        end else if (ce) begin
            if (stbEvent && !newDiff) begin
                capLo_r <= s3_r[W-1:0];
            end
            if (stbEvent && newDiff) begin
                capHi_r   <= s3_r[W-1:0];
                capFull_r <= 1'h1;
            end else if (busEdge) begin
                capFull_r <= 1'h0;
            end
        end
    end

    // a captured pair is taken over at a bus edge only when the qualifier
    // was seen asserted; a pair without it is dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            moveLo_r  <= '0;
            moveHi_r  <= '0;
            moveCnt_r <= 2'h0;
        end else if (ce) begin
            if (busEdge && validLvl_r && capFull_r) begin
                moveLo_r  <= capLo_r;
                moveHi_r  <= capHi_r;
                moveCnt_r <= 2'h2;
            end else if (moveCnt_r != 2'h0 && fifoReady) begin
                moveCnt_r <= moveCnt_r - 2'h1;
            end
        end
    end

    // hold the sender off early enough to cover pairs already in flight
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blkOe_r <= 1'h0;
        end else if (ce && busEdge) begin
            blkOe_r <= fifoLevel >= (AW+1)'(`SSB_BLOCK_LEVEL);
        end
    end

    ssb_fifo #(
        .WIDTH (W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .inValid  (moveCnt_r != 2'h0),
        .inReady  (fifoReady),
        .inData   (moveCnt_r == 2'h2 ? moveLo_r : moveHi_r),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outData),
        .level    (fifoLevel)
    );
endmodule : ssb_receiver

`default_nettype wire

// File: bench/ssb_link_monitor.sv
// ssb_link_monitor: timing checks on the wires between both link ends
// assumes the sender makes the bus clock, 8 local clocks per period
`timescale 1ns/1ps
`default_nettype none

module ssb_link_monitor #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic         clk,
    input wire logic         sys_rst,
    // sender side wires
    input wire logic         busClk,
    input wire logic [W-1:0] dataOut,
    input wire logic         dataOe,
    input wire logic         dataStrobePosOut,
    input wire logic         dataStrobeNegOut,
    input wire logic         dataStrobeOe,
    input wire logic         busDataValid,
    // shared hold-off wire
    input wire logic         blockNextRequest
);
    logic       busQ_r;
    logic [2:0] phase_r;
    logic [2:0] ph;
    logic [4:0] hiCnt_r;
    logic [3:0] loCnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // phase of the sampled cycle, 0 where the bus clock has just risen
    assign ph = (busClk && !busQ_r) ? 3'h0 : phase_r;

    always_ff @(posedge clk) begin
        busQ_r  <= sys_rst | busClk;
        phase_r <= sys_rst ? 3'h0 : ph + 3'h1;
    end

    // runs of the hold-off wire; low run starts saturated after reset
    always_ff @(posedge clk) begin
        if (sys_rst || !blockNextRequest) hiCnt_r <= 5'h0;
        else if (hiCnt_r != 5'h1F) hiCnt_r <= hiCnt_r + 5'h1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) loCnt_r <= 4'hF;
        else if (blockNextRequest) loCnt_r <= 4'h0;
        else if (loCnt_r != 4'hF) loCnt_r <= loCnt_r + 4'h1;
    end

    a_clock_divide: assert property (
        $rose(busClk) |-> busClk[*4] ##1 !busClk[*4] ##1 busClk)
        else $error("bus clock period is not 8 local clocks");
    a_data_launch: assert property (
        dataOe && $past(dataOe) && $changed(dataOut) |->
        ph == 3'h0 || ph == 3'h4)
        else $error("data changed away from period start or midpoint");
    a_strobe_quarter: assert property (
        dataStrobeOe && $past(dataStrobeOe) && $changed(dataStrobePosOut)
        |-> ph == 3'h2 || ph == 3'h6)
        else $error("strobe edge away from quarter points");
    a_strobe_edges: assert property (
        $rose(busDataValid) |-> dataStrobePosOut ##2
        (!dataStrobePosOut && dataStrobeNegOut) ##4
        (dataStrobePosOut && !dataStrobeNegOut))
        else $error("strobes lack a fall and rise within the transfer");
    a_strobe_diff: assert property (
        dataStrobeOe |-> dataStrobePosOut != dataStrobeNegOut)
        else $error("driven strobes are not complementary");
    a_pre_drive: assert property (
        $rose(dataStrobeOe) |-> (dataStrobePosOut && !dataOe)[*8] ##1 dataOe)
        else $error("strobe not pre-driven one period before data");
    a_valid_frame: assert property (
        $changed(dataOe) |-> $changed(busDataValid) && ph == 3'h0)
        else $error("qualifier not aligned with driven data");
    a_valid_edge: assert property (
        $changed(busDataValid) |-> ph == 3'h0 && busDataValid == dataOe)
        else $error("qualifier changed away from bus clock rise");
    a_strobe_release: assert property (
        $fell(dataOe) |-> $fell(dataStrobeOe))
        else $error("strobes still driven after last data");
    a_block_stops: assert property (
        hiCnt_r >= 5'd24 |-> !dataOe)
        else $error("data still sent long after hold-off raised");
    a_settle_wait: assert property (
        $rose(dataStrobeOe) |-> loCnt_r >= 4'd9)
        else $error("transfer started before hold-off settled");
endmodule : ssb_link_monitor

`default_nettype wire

// File: bench/tb_top.sv
// tb_top: sender and receiver joined by the link, user sides driven here
// assumes the sender makes the bus clock; inputs change on falling clk
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int W = 32;
    logic         clk;
    logic         sys_rst;
    logic         inValid;
    logic         inReady;
    logic [W-1:0] inData;
    logic         outValid;
    logic         outReady;
    logic [W-1:0] outData;
    int           num_errors;
    int           cmp_count;

    ssb_link_if #(.W(W)) u_ssb_link_if ();
    // clock enable tied: freezing is not exercised
    ssb_sender #(.W(W)) u_ssb_sender (.clk(clk), .sys_rst(sys_rst),
        .ce(1'b1), .inValid(inValid), .inReady(inReady), .inData(inData),
        .link(u_ssb_link_if));
    ssb_receiver #(.W(W), .DEPTH(16)) u_ssb_receiver (.clk(clk),
        .sys_rst(sys_rst), .ce(1'b1), .outValid(outValid),
        .outReady(outReady), .outData(outData), .link(u_ssb_link_if));
    ssb_link_monitor #(.W(W)) u_ssb_link_monitor (.clk(clk),
        .sys_rst(sys_rst), .busClk(u_ssb_link_if.busClk),
        .dataOut(u_ssb_link_if.dataOut), .dataOe(u_ssb_link_if.dataOe),
        .dataStrobePosOut(u_ssb_link_if.dataStrobePosOut),
        .dataStrobeNegOut(u_ssb_link_if.dataStrobeNegOut),
        .dataStrobeOe(u_ssb_link_if.dataStrobeOe),
        .busDataValid(u_ssb_link_if.busDataValid),
        .blockNextRequest(u_ssb_link_if.blockNextRequest));

    task automatic chk(input string nm, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // offers words base, base+1, ...; inReady looked at before each edge
    task automatic push(input int n, input logic [W-1:0] base);
        int t;
        for (int i = 0; i < n; i++) begin
            inValid = 1'b1;
            inData  = base + W'(i);
            t = 0;
            while (inReady !== 1'b1 && t < 2000) begin
                @(negedge clk);
                t++;
            end
            if (t >= 2000) num_errors++;
            @(negedge clk);
        end
        inValid = 1'b0;
    endtask : push

    task automatic pull(input int n, input logic [W-1:0] base);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            while (outValid !== 1'b1 && t < 2000) begin
                outReady = 1'b0;
                @(negedge clk);
                t++;
            end
            if (t >= 2000) num_errors++;
            chk("outData", outData, base + W'(i));
            outReady = 1'b1;
            @(negedge clk);
        end
        outReady = 1'b0;
    endtask : pull

    task automatic t_idle();
        chk("strobePos", u_ssb_link_if.dataStrobePos, 1);
        chk("strobeNeg", u_ssb_link_if.dataStrobeNeg, 0);
        chk("dataBus", u_ssb_link_if.dataBus, 0);
        chk("dataValid", u_ssb_link_if.busDataValid, 0);
        chk("blockNext", u_ssb_link_if.blockNextRequest, 0);
        chk("outValid", outValid, 0);
        chk("inReady", inReady, 1);
        $display("t_idle done");
    endtask : t_idle

    // one pair watched on the wires phase by phase, low word first
    task automatic t_pair();
        int t;
        fork
            push(2, 32'hC3A5_0F00);
        join_none
        t = 0;
        while (u_ssb_link_if.busDataValid !== 1'b1 && t < 100) begin
            @(negedge clk);
            t++;
        end
        if (t >= 100) num_errors++;
        for (int i = 0; i < 9; i++) begin
            chk("dataBus", u_ssb_link_if.dataBus, i == 8 ? 32'h0 :
                (i < 4 ? 32'hC3A5_0F00 : 32'hC3A5_0F01));
            chk("strobePos", u_ssb_link_if.dataStrobePos,
                i < 2 || i >= 6);
            chk("strobeNeg", u_ssb_link_if.dataStrobeNeg,
                i >= 2 && i < 6);
            chk("dataValid", u_ssb_link_if.busDataValid, i < 8);
            @(negedge clk);
        end
        pull(2, 32'hC3A5_0F00);
        $display("t_pair done");
    endtask : t_pair

    // three pairs back to back: one qualified period per pair
    task automatic t_burst();
        int cnt;
        cnt = 0;
        fork
            push(6, 32'h1000_0000);
            pull(6, 32'h1000_0000);
            repeat (200) begin
                @(negedge clk);
                if (u_ssb_link_if.busDataValid === 1'b1) cnt++;
            end
        join
        chk("validCycles", cnt, 24);
        $display("t_burst done");
    endtask : t_burst

    // receiver stalls, its buffer fills and holds the sender off
    task automatic t_block();
        fork
            push(20, 32'h7E00_0000);
            begin
                repeat (400) @(negedge clk);
                chk("blockNext", u_ssb_link_if.blockNextRequest, 1);
                chk("inReady", inReady, 0);
                pull(20, 32'h7E00_0000);
            end
        join
        repeat (40) @(negedge clk);
        chk("blockNext", u_ssb_link_if.blockNextRequest, 0);
        $display("t_block done");
    endtask : t_block

    // reset lands in mid-transfer; the link must fall back to idle
    task automatic t_abort();
        int t;
        fork
            push(2, 32'h0BAD_0000);
        join_none
        t = 0;
        while (u_ssb_link_if.busDataValid !== 1'b1 && t < 100) begin
            @(negedge clk);
            t++;
        end
        if (t >= 100) num_errors++;
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        t_idle();
        $display("t_abort done");
    endtask : t_abort

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        num_errors = 0;
        cmp_count  = 0;
        sys_rst    = 1'b1;
        inValid    = 1'b0;
        inData     = '0;
        outReady   = 1'b0;
        fork
            begin
                repeat (20000) @(posedge clk);
                num_errors++;
                give_verdict();
            end
        join_none
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        t_idle();
        t_pair();
        t_burst();
        t_block();
        t_abort();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
